//--- nirq_pkg.sv
// Shared constants for the nested interrupt controller
package nirq_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_IRQ = 32;
   localparam int PRIO_BITS = 2;
   localparam int PRIO_FIELD = 8;
   localparam int PRIO_LANES = 4;
   localparam int PRIO_REGS = 8;
   localparam int ID_BITS = 5;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the private peripheral bus)
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_ENABLE_SET = 32'he000e100;
   localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'he000e180;
   localparam logic [31:0] ADDR_PENDING_SET = 32'he000e200;
   localparam logic [31:0] ADDR_PENDING_CLEAR = 32'he000e280;
   localparam logic [31:0] ADDR_PRIORITY_FIRST = 32'he000e400;
   localparam logic [31:0] ADDR_PRIORITY_LAST = 32'he000e41c;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int PRIO_INDEX_LSB = 2;
   localparam int PRIO_STORED_LSB = 6;
   localparam logic [31:0] PRIO_UNUSED_MASK = 32'h3f3f3f3f;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [1:0] RESET_PRIO = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] PRIO_LEAST_URGENT = 2'h3;
endpackage

//--- nirq_controller.sv
// Nested vectored interrupt controller: 32 lines, NMI, priority arbiter
// Function
// - One enable bit per line, line n at bit n of the enable word.
// - Each line has a priority 0..192 in steps of 64.
// - Numerically lower priority level wins arbitration; level zero is most urgent.
// - Requests are caught whether held as levels or given as single pulses.
// - A separate non-maskable input bypasses the per-line enables.
// - Core saves and restores state itself; entry and return are plain strobes here.
// - Set-enable write of one enables; zero does nothing; read shows enables.
// - Pending, enabled and not active lines are forwarded to the core by priority.
// - Disabled lines still go pending but are never forwarded.
// - Clear-enable write of one disables; zero does nothing; read shows enables.
// - Set-pending write of one makes pending; zero does nothing; read shows pending.
// - Set-pending on a pending line changes nothing; disabled lines still go pending.
// - Clear-pending write of one removes pending; zero does nothing; read shows pending.
// - Clear-pending never changes the active state.
// - Eight priority words, four 8-bit fields each, word accesses only.
// - Only bits 7:6 of a field are stored; bits 5:0 read zero.
// - Line M sits in priority word M/4, byte lane M mod 4.
// - Pulses are sampled on the rising clock; peripheral holds them one cycle.
// - On service entry the line loses pending and becomes active.
// - On level return the line is resampled: asserted means pending again.
// - Clear-pending leaves asserted level lines alone; pulse lines drop pending only.
module nirq_controller (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [31:0] irqLines,
   input wire logic nmiIn,
   input wire logic [31:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [1:0] busSize,
   input wire logic [31:0] busWdata,
   output logic [31:0] busRdata,
   output logic busErr,
   output logic irqReq,
   output logic [4:0] irqId,
   output logic [1:0] irqPrio,
   input wire logic irqTake,
   input wire logic [4:0] irqTakeId,
   input wire logic irqReturn,
   input wire logic [4:0] irqRetId,
   output logic nmiReq
);

   typedef struct packed {
      logic [31:0] enable;
      logic [31:0] pending;
      logic [31:0] active;
      logic [31:0][1:0] prio;
      logic [31:0] lineSeen;
      logic [31:0] rdata;
      logic err;
      logic nmiMeta;
      logic nmiSync;
   } nirq_state_s;

   nirq_state_s state_ff;
   nirq_state_s nxt_state;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic hitEnSet;
   logic hitEnClr;
   logic hitPdSet;
   logic hitPdClr;
   logic hitPrio;
   logic [2:0] prioIdx;

   always_comb begin
      hitEnSet = 1'b0;
      hitEnClr = 1'b0;
      hitPdSet = 1'b0;
      hitPdClr = 1'b0;
      hitPrio = 1'b0;
      if (busAddr == nirq_pkg::ADDR_ENABLE_SET) begin
         hitEnSet = 1'b1;
      end else if (busAddr == nirq_pkg::ADDR_ENABLE_CLEAR) begin
         hitEnClr = 1'b1;
      end else if (busAddr == nirq_pkg::ADDR_PENDING_SET) begin
         hitPdSet = 1'b1;
      end else if (busAddr == nirq_pkg::ADDR_PENDING_CLEAR) begin
         hitPdClr = 1'b1;
      end else if (busAddr >= nirq_pkg::ADDR_PRIORITY_FIRST &&
                   busAddr <= nirq_pkg::ADDR_PRIORITY_LAST &&
                   busAddr[1:0] == 2'h0) begin
         hitPrio = 1'b1;
      end
   end

   assign prioIdx = busAddr[nirq_pkg::PRIO_INDEX_LSB +: 3];

   // ----------------------------------------------------------------
   // Arbiter
   // ----------------------------------------------------------------
   logic [31:0] candidates;
   logic found;
   logic [4:0] bestId;
   logic [1:0] bestPrio;

   assign candidates = state_ff.pending & state_ff.enable & ~state_ff.active;

   always_comb begin
      found = 1'b0;
      bestId = 5'h0;
      bestPrio = nirq_pkg::PRIO_LEAST_URGENT;
      // Strict compare while scanning upward keeps the lowest number on ties
      for (int i = 0; i < nirq_pkg::NUM_IRQ; i++) begin
         if (candidates[i] && (!found || state_ff.prio[i] < bestPrio)) begin
            found = 1'b1;
            bestId = 5'(i);
            bestPrio = state_ff.prio[i];
         end
      end
   end

   // Combinational so a return sees the next winner on the following cycle
   assign irqReq = found;
   assign irqId = bestId;
   assign irqPrio = bestPrio;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic wordOk;
   logic [31:0] takeMask;
   logic [31:0] retMask;
   logic [31:0] riseMask;

   assign wordOk = busSize == nirq_pkg::SIZE_WORD;

   always_comb begin
      logic [31:0] pending_clear_bits;
      logic [31:0] pending_set_bits;
      pending_clear_bits = 32'h0;
      pending_set_bits = 32'h0;
      nxt_state = state_ff;
      nxt_state.err = 1'b0;
      takeMask = 32'h0;
      retMask = 32'h0;

      // Two-flop sync; only the second stage is read
      nxt_state.nmiMeta = nmiIn;
      nxt_state.nmiSync = state_ff.nmiMeta;

      // Peripheral lines share the clock: sampled on the rising edge
      nxt_state.lineSeen = irqLines;
      riseMask = irqLines & ~state_ff.lineSeen;

      // Entry only honoured for a line that is really pending and enabled
      if (irqTake && candidates[irqTakeId]) begin
         takeMask[irqTakeId] = 1'b1;
      end
      if (irqReturn) begin
         retMask[irqRetId] = 1'b1;
      end
      // Core stacks on entry and unstacks on return: only the strobes reach here
      nxt_state.active = (state_ff.active | takeMask) & ~retMask;
      pending_clear_bits = takeMask;

      if (busWrite && hitEnSet) begin
         nxt_state.enable = state_ff.enable | busWdata;
      end
      if (busWrite && hitEnClr) begin
         nxt_state.enable = state_ff.enable & ~busWdata;
      end
      if (busWrite && hitPdSet) begin
         pending_set_bits = busWdata;
      end
      if (busWrite && hitPdClr) begin
         // Asserted lines keep their state; active untouched
         pending_clear_bits = pending_clear_bits | (busWdata & ~irqLines);
      end

      // Level held while inactive, or a fresh edge, or a level still up on return
      pending_set_bits = pending_set_bits | riseMask;
      pending_set_bits = pending_set_bits | (irqLines & ~nxt_state.active);

      // Hardware set wins over a clear in the same cycle
      nxt_state.pending = (state_ff.pending & ~pending_clear_bits) | pending_set_bits;

      if (busWrite && hitPrio) begin
         if (wordOk) begin
            for (int k = 0; k < nirq_pkg::PRIO_LANES; k++) begin
               // Only the two top bits of each byte are kept
               nxt_state.prio[4 * prioIdx + k] =
                  busWdata[k * nirq_pkg::PRIO_FIELD + nirq_pkg::PRIO_STORED_LSB +: 2];
            end
         end else begin
            nxt_state.err = 1'b1;
         end
      end

      nxt_state.rdata = nirq_pkg::RESET_WORD;
      if (busRead) begin
         if (hitEnSet || hitEnClr) begin
            nxt_state.rdata = state_ff.enable;
         end else if (hitPdSet || hitPdClr) begin
            nxt_state.rdata = state_ff.pending;
         end else if (hitPrio) begin
            if (wordOk) begin
               for (int k = 0; k < nirq_pkg::PRIO_LANES; k++) begin
                  nxt_state.rdata[k * nirq_pkg::PRIO_FIELD + nirq_pkg::PRIO_STORED_LSB +: 2] =
                     state_ff.prio[4 * prioIdx + k];
               end
            end else begin
               nxt_state.err = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff.enable <= nirq_pkg::RESET_WORD;
         state_ff.pending <= nirq_pkg::RESET_WORD;
         state_ff.active <= nirq_pkg::RESET_WORD;
         state_ff.prio <= {nirq_pkg::NUM_IRQ{nirq_pkg::RESET_PRIO}};
         state_ff.lineSeen <= nirq_pkg::RESET_WORD;
         state_ff.rdata <= nirq_pkg::RESET_WORD;
         state_ff.err <= 1'b0;
         state_ff.nmiMeta <= 1'b0;
         state_ff.nmiSync <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign busRdata = state_ff.rdata;
   assign busErr = state_ff.err;
   assign nmiReq = state_ff.nmiSync;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_enable_set: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitEnSet |=> (state_ff.enable & $past(busWdata)) == $past(busWdata))
      else $error("Set-enable write did not enable");

   a_enable_clear: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitEnClr |=> (state_ff.enable & $past(busWdata)) == 32'h0)
      else $error("Clear-enable write did not disable");

   a_pending_set: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitPdSet && !irqTake |=>
         (state_ff.pending & $past(busWdata)) == $past(busWdata))
      else $error("Set-pending write lost");

   a_never_disabled: assert property (@(posedge clock) disable iff (!nrst)
      irqReq |-> state_ff.enable[irqId] && state_ff.pending[irqId])
      else $error("Disabled or idle line forwarded");

   a_take_active: assert property (@(posedge clock) disable iff (!nrst)
      irqTake && candidates[irqTakeId] && !irqReturn |=>
         state_ff.active[$past(irqTakeId)])
      else $error("Taken line not active");

   a_pending_clear_bits_active: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitPdClr && !irqTake && !irqReturn |=>
         state_ff.active == $past(state_ff.active))
      else $error("Clear-pending changed active state");

   a_prio_low_bits: assert property (@(posedge clock) disable iff (!nrst)
      busRead && hitPrio |=> (busRdata & nirq_pkg::PRIO_UNUSED_MASK) == 32'h0)
      else $error("Unimplemented priority bits read nonzero");

   a_prio_word_only: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitPrio && !wordOk |=> busErr && state_ff.prio == $past(state_ff.prio))
      else $error("Narrow priority write took effect");

   a_level_pend: assert property (@(posedge clock) disable iff (!nrst)
      (irqLines & ~state_ff.active & ~takeMask) != 32'h0 |=>
         (state_ff.pending & $past(irqLines & ~state_ff.active & ~takeMask)) ==
            $past(irqLines & ~state_ff.active & ~takeMask))
      else $error("Held level did not pend");

   a_nmi_path: assert property (@(posedge clock) disable iff (!nrst)
      nmiIn [*3] |-> nmiReq)
      else $error("NMI not forwarded in two cycles");

   a_nmi_quiet: assert property (@(posedge clock) disable iff (!nrst)
      !nmiIn [*3] |-> !nmiReq)
      else $error("NMI raised without input");

   a_pending_clear_bits_level: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitPdClr && !irqTake |=>
         (state_ff.pending & $past(busWdata & irqLines & state_ff.pending)) ==
            $past(busWdata & irqLines & state_ff.pending))
      else $error("Clear-pending dropped an asserted level line");

   a_pending_clear_bits_pulse: assert property (@(posedge clock) disable iff (!nrst)
      busWrite && hitPdClr |=> (state_ff.pending & $past(busWdata & ~irqLines)) == 32'h0)
      else $error("Clear-pending left a quiet line pending");

   a_return_repend: assert property (@(posedge clock) disable iff (!nrst)
      irqReturn && irqLines[irqRetId] |=>
         state_ff.pending[$past(irqRetId)] && !state_ff.active[$past(irqRetId)])
      else $error("Held level not pending again after return");

   a_take_clears: assert property (@(posedge clock) disable iff (!nrst)
      irqTake && candidates[irqTakeId] && !irqLines[irqTakeId] && !(busWrite && hitPdSet) |=>
         !state_ff.pending[$past(irqTakeId)])
      else $error("Taken line still pending");

endmodule // nirq_controller

//--- nirq_core_model.sv
// Core-side partner: takes offered interrupts on command
module nirq_core_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic irqReq,
   input wire logic [4:0] irqId,
   input wire logic acceptEn,
   output logic irqTake,
   output logic [4:0] irqTakeId
);
   timeunit 1ns;
   timeprecision 100ps;
   // Offer still shows at the take edge, so never take twice in a row
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqTake <= 1'b0;
         irqTakeId <= 5'h0;
      end else begin
         irqTake <= acceptEn && irqReq && !irqTake;
         irqTakeId <= irqTake ? ~irqTakeId : irqId;
      end
   end
endmodule // nirq_core_model

//--- nirq_controller_tb.sv
// Self-checking bench for the nested interrupt controller
module nirq_controller_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ENS = nirq_pkg::ADDR_ENABLE_SET;
   localparam logic [31:0] ENC = nirq_pkg::ADDR_ENABLE_CLEAR;
   localparam logic [31:0] PDS = nirq_pkg::ADDR_PENDING_SET;
   localparam logic [31:0] PDC = nirq_pkg::ADDR_PENDING_CLEAR;
   localparam logic [31:0] PR0 = nirq_pkg::ADDR_PRIORITY_FIRST;
   logic clock = 1'b0, nrst = 1'b0, nmiIn = 1'b0, busWrite = 1'b0, busRead = 1'b0;
   logic [31:0] irqLines = '0, busAddr = '0, busWdata = '0, busRdata, rdData;
   logic [1:0] busSize = 2'h2, irqPrio;
   logic busErr, irqReq, nmiReq, irqTake, irqReturn = 1'b0, acceptEn = 1'b0, errSeen;
   logic [4:0] irqId, irqTakeId, irqRetId = '0;
   int errCount = 0;
   int checked = 0;
   nirq_controller dut_u (.clock, .nrst, .irqLines, .nmiIn, .busAddr, .busWrite,
      .busRead, .busSize, .busWdata, .busRdata, .busErr, .irqReq, .irqId, .irqPrio,
      .irqTake, .irqTakeId, .irqReturn, .irqRetId, .nmiReq);
   nirq_core_model core_u (.clock, .nrst, .irqReq, .irqId, .acceptEn, .irqTake,
      .irqTakeId);
   initial begin
      forever #2 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // Bus and core helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d,
         input logic [1:0] sz);
      @(negedge clock);
      busAddr = a;
      busWrite = w;
      busRead = !w;
      busWdata = d;
      busSize = sz;
      @(negedge clock);
      busWrite = 1'b0;
      busRead = 1'b0;
      rdData = busRdata;
      errSeen = busErr;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      acc(a, 1'b1, d, 2'h2);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      acc(a, 1'b0, '0, 2'h2);
      chk(rdData, e);
   endtask
   task automatic ofr(input logic r, input logic [4:0] i, input logic [1:0] p);
      chk({24'h0, irqPrio, irqReq, irqId}, {24'h0, p, r, i});
   endtask
   task automatic take();
      @(negedge clock);
      acceptEn = 1'b1;
      @(negedge clock);
      acceptEn = 1'b0;
   endtask
   task automatic ret(input logic [4:0] id);
      @(negedge clock);
      irqReturn = 1'b1;
      irqRetId = id;
      @(negedge clock);
      irqReturn = 1'b0;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 4; i++)
         rd(ENS + 32'(i) * 32'h80, '0);
      for (int i = 0; i < 8; i++)
         rd(PR0 + 32'(i) * 32'h4, '0);
   endtask
   task automatic t_enable();
      wr(ENS, 32'h80000001);
      rd(ENC, 32'h80000001);
      wr(ENS, '0);
      wr(ENC, '0);
      rd(ENS, 32'h80000001);
      wr(ENC, 32'h00000001);
      rd(ENS, 32'h80000000);
      wr(ENC, '1);
   endtask
   task automatic t_prio();
      wr(PR0 + 32'h1c, 32'hffffffff);
      rd(PR0 + 32'h1c, 32'hc0c0c0c0);
      acc(PR0 + 32'h1c, 1'b1, '0, 2'h0);
      chk({31'h0, errSeen}, 32'h1);
      rd(PR0 + 32'h1c, 32'hc0c0c0c0);
      wr(PR0 + 32'h1c, '0);
   endtask
   task automatic t_arb();
      wr(ENS, 32'h00002220);
      wr(PR0 + 32'h4, 32'h00004000);
      wr(PDS, 32'h00002224);
      rd(PDS, 32'h00002224);
      ofr(1'b1, 5'd9, 2'h0);
      wr(PDS, 32'h00000200);
      rd(PDS, 32'h00002224);
      take();
      rd(PDS, 32'h00002024);
      ret(5'd9);
      ofr(1'b1, 5'd13, 2'h0);
      wr(PDC, 32'h00002000);
      ofr(1'b1, 5'd5, 2'h1);
      wr(PDC, 32'h00000024);
      rd(PDS, '0);
      ofr(1'b0, 5'd0, nirq_pkg::PRIO_LEAST_URGENT);
      wr(ENC, '1);
   endtask
   task automatic t_level();
      @(negedge clock);
      irqLines[4] = 1'b1;
      wr(ENS, 32'h00000010);
      rd(PDS, 32'h00000010);
      take();
      rd(PDS, '0);
      ofr(1'b0, 5'd0, nirq_pkg::PRIO_LEAST_URGENT);
      ret(5'd4);
      rd(PDS, 32'h00000010);
      wr(PDC, 32'h00000010);
      rd(PDS, 32'h00000010);
      irqLines[4] = 1'b0;
      wr(PDC, 32'h00000010);
      rd(PDS, '0);
      wr(ENC, '1);
   endtask
   task automatic t_pulse();
      @(negedge clock);
      irqLines[6] = 1'b1;
      @(negedge clock);
      irqLines[6] = 1'b0;
      rd(PDS, 32'h00000040);
      wr(PDC, 32'h00000040);
      rd(PDS, '0);
   endtask
   task automatic t_nmi();
      @(negedge clock);
      nmiIn = 1'b1;
      @(negedge clock);
      chk({31'h0, nmiReq}, 32'h0);
      @(negedge clock);
      chk({31'h0, nmiReq}, 32'h1);
      @(negedge clock);
      nmiIn = 1'b0;
      chk({31'h0, nmiReq}, 32'h1);
      @(negedge clock);
      chk({31'h0, nmiReq}, 32'h1);
      @(negedge clock);
      chk({31'h0, nmiReq}, 32'h0);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Whole run is under 130 cycles; ten microseconds is ample
   initial begin
      #10000;
      errCount++;
      results();
   end
   initial begin
      repeat (8) @(negedge clock);
      nrst = 1'b1;
      t_reset();
      t_enable();
      t_prio();
      t_arb();
      t_level();
      t_pulse();
      t_nmi();
      results();
   end
endmodule // nirq_controller_tb
